// file: hw/uif_consts.vh
/*
 Constants of the USB interrupt force and status block: register byte
 offsets, field positions, reset values and bus response codes.
 Assumes inclusion by bare name from the hw/ design files.
*/
// Contract
// - Read-only status view: masked raw, plus force
// - Bit 19 high while any halt/nack flag set
// - Bit 18 high while any abort-done flag set
// - Device role: bit 17 frame start, clear on read
// - Device role: bit 15 on host resume, clear by resume write
// - Device role: bit 14 on sleep change, clear by write
// - Device role: bit 13 on attach change, clear by write
// - Bit 4 high while any buffer-done flag set
// - Bit 3 on transfer finished rise, write clears
// - Host role: bit 2 frame sent, clear on read
// - Host role: bit 1 device wake, resume write clears
// - Host role: bit 0 speed change, speed write clears
`ifndef UIF_CONSTS_VH
`define UIF_CONSTS_VH

`define UIF_ADDR_W       8
`define UIF_SRC_N        20
`define UIF_EV_N         8

`define UIF_OFF_RAW      8'h8C
`define UIF_OFF_ENABLE   8'h90
`define UIF_OFF_FORCE    8'h94
`define UIF_OFF_MASKED   8'h98

`define UIF_ENABLE_RST   20'h00000
`define UIF_FORCE_RST    20'h00000

`define UIF_B_EPHALT     19
`define UIF_B_ABORT      18
`define UIF_B_DEVSOF     17
`define UIF_B_SETUP      16
`define UIF_B_DEVWAKE    15
`define UIF_B_SLEEP      14
`define UIF_B_DEVATT     13
`define UIF_B_BUSRST     12
`define UIF_B_VBUS       11
`define UIF_B_HALT       10
`define UIF_B_CRC        9
`define UIF_B_STUFF      8
`define UIF_B_RXOVF      7
`define UIF_B_RXTMO      6
`define UIF_B_TOGGLE     5
`define UIF_B_BUFDONE    4
`define UIF_B_XFER       3
`define UIF_B_HOSTSOF    2
`define UIF_B_HOSTWAKE   1
`define UIF_B_HOSTATT    0

`define UIF_RESP_OKAY    2'h0
`define UIF_RESP_SLVERR  2'h2

`endif

// file: hw/uif_sticky.v
/*
 Bank of sticky event flags, one per bit, set wins over clear.
 Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module uif_sticky #(
   parameter N = 8
) (
   input  wire         clk,   // Bus clock
   input  wire         srst,  // Synchronous reset, high
   input  wire [N-1:0] set,   // Event pulses
   input  wire [N-1:0] clr,   // Clear requests
   output wire [N-1:0] flags  // Sticky flags
);

   reg  [N-1:0] flag_q;
   genvar       i;

   generate
      for (i = 0; i < N; i = i + 1) begin : gBit
         // An event in the clearing cycle must not be lost
         always @(posedge clk) begin
            if (srst) begin
               flag_q[i] <= 1'b0;
            end else if (set[i]) begin
               flag_q[i] <= 1'b1;
            end else if (clr[i]) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_q;

endmodule
`default_nettype wire

// file: hw/uif_axil_slave.v
/*
 AXI4-Lite slave front end: takes one write and one read at a time and
 hands a single-cycle access to the register file.
 Assumes a register file that decodes combinationally on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

`include "uif_consts.vh"

module uif_axil_slave #(
   parameter AW = 8
) (
   input  wire          clk,      // Bus clock
   input  wire          srst,     // Synchronous reset, high
   input  wire [AW-1:0] awaddr,   // Write address
   input  wire          awvalid,  // Write address valid
   output wire          awready,  // Write address ready
   input  wire [31:0]   wdata,    // Write data
   input  wire [3:0]    wstrb,    // Write byte strobes
   input  wire          wvalid,   // Write data valid
   output wire          wready,   // Write data ready
   output wire [1:0]    bresp,    // Write response
   output wire          bvalid,   // Write response valid
   input  wire          bready,   // Write response ready
   input  wire [AW-1:0] araddr,   // Read address
   input  wire          arvalid,  // Read address valid
   output wire          arready,  // Read address ready
   output wire [31:0]   rdata,    // Read data
   output wire [1:0]    rresp,    // Read response
   output wire          rvalid,   // Read data valid
   input  wire          rready,   // Read data ready
   output wire          wrEn,     // Write strobe to registers
   output wire [AW-1:0] wrAddr,   // Write address to registers
   output wire [31:0]   wrData,   // Write data to registers
   output wire [31:0]   wrMask,   // Bit mask from strobes
   input  wire          wrOk,     // Write address is mapped
   output wire [AW-1:0] rdAddr,   // Read address to registers
   input  wire [31:0]   rdData,   // Read data from registers
   input  wire          rdOk      // Read address is mapped
);

   reg          awHeld_q;
   reg [AW-1:0] awAddr_q;
   reg          wHeld_q;
   reg [31:0]   wData_q;
   reg [3:0]    wStrb_q;
   reg          bValid_q;
   reg [1:0]    bResp_q;
   reg          rValid_q;
   reg [31:0]   rData_q;
   reg [1:0]    rResp_q;

   assign awready = ~awHeld_q & ~bValid_q;
   assign wready  = ~wHeld_q & ~bValid_q;
   assign arready = ~rValid_q;
   assign wrEn    = awHeld_q & wHeld_q;
   assign wrAddr  = awAddr_q;
   assign wrData  = wData_q;
   assign wrMask  = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                     {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   assign rdAddr  = araddr;
   assign bvalid  = bValid_q;
   assign bresp   = bResp_q;
   assign rvalid  = rValid_q;
   assign rdata   = rData_q;
   assign rresp   = rResp_q;

   // Address and data are taken in either order, then written together
   always @(posedge clk) begin
      if (srst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= {AW{1'b0}};
         wHeld_q  <= 1'b0;
         wData_q  <= 32'h00000000;
         wStrb_q  <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q  <= `UIF_RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wvalid & wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (wrEn) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b1;
            bResp_q  <= wrOk ? `UIF_RESP_OKAY : `UIF_RESP_SLVERR;
         end else if (bValid_q & bready) begin
            bValid_q <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         rValid_q <= 1'b0;
         rData_q  <= 32'h00000000;
         rResp_q  <= `UIF_RESP_OKAY;
      end else if (arvalid & arready) begin
         rValid_q <= 1'b1;
         rData_q  <= rdOk ? rdData : 32'h00000000;
         rResp_q  <= rdOk ? `UIF_RESP_OKAY : `UIF_RESP_SLVERR;
      end else if (rValid_q & rready) begin
         rValid_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: hw/uif_irq_top.v
/*
 USB interrupt aggregation: twenty raw sources, enable, force and the
 masked status view, with one level interrupt output.
 Assumes all source inputs come from engine logic on the same clock;
 clear strobes are single-cycle pulses from the engine register file.
*/
`timescale 1ns/1ns
`default_nettype none

`include "uif_consts.vh"

module uif_irq_top #(
   parameter EP_N  = 32,  // Endpoint flag count
   parameter BUF_N = 32   // Buffer flag count
) (
   // Clock and reset
   input  wire                  clk,                   // Bus clock
   input  wire                  srst,                  // Sync reset, high
   // Register bus
   input  wire [`UIF_ADDR_W-1:0] awaddr,               // AXI write address
   input  wire                  awvalid,               // AXI aw valid
   output wire                  awready,               // AXI aw ready
   input  wire [31:0]           wdata,                 // AXI write data
   input  wire [3:0]            wstrb,                 // AXI byte strobes
   input  wire                  wvalid,                // AXI w valid
   output wire                  wready,                // AXI w ready
   output wire [1:0]            bresp,                 // AXI write resp
   output wire                  bvalid,                // AXI b valid
   input  wire                  bready,                // AXI b ready
   input  wire [`UIF_ADDR_W-1:0] araddr,               // AXI read address
   input  wire                  arvalid,               // AXI ar valid
   output wire                  arready,               // AXI ar ready
   output wire [31:0]           rdata,                 // AXI read data
   output wire [1:0]            rresp,                 // AXI read resp
   output wire                  rvalid,                // AXI r valid
   input  wire                  rready,                // AXI r ready

   // Role, arrays
   input  wire                  hostRole,              // 1 host, 0 device
   input  wire [EP_N-1:0]       endpointHaltNackFlags, // Halt/nack array
   input  wire [EP_N-1:0]       abortDoneFlags,        // Abort-done array
   input  wire [BUF_N-1:0]      bufferDoneFlags,       // Buffer-done array

   // Events, clears
   input  wire                  deviceFrameStart,      // Frame start rx
   input  wire                  hostFrameSent,         // Frame start tx
   input  wire                  frameNumRead,          // Frame reg read
   input  wire                  deviceWakeFromHost,    // Resume from host
   input  wire                  hostWake,              // Device woke host
   input  wire                  resumeFlagWrite,       // Resume flag write
   input  wire                  sleepStateFlag,        // Sleep_state_flag state
   input  wire                  sleepFlagWrite,        // Sleep_state_flag write
   input  wire                  attachState,           // Connected state
   input  wire                  attachFlagWrite,       // Connected write
   input  wire                  transferFinished,      // Transfer flag
   input  wire [1:0]            speedField,            // Detected speed
   input  wire                  speedFieldWrite,       // Speed field write

   // Mirrored levels
   input  wire                  setupPacketReceived,   // Setup flag
   input  wire                  busReset,              // Bus reset flag
   input  wire                  busPowerPresent,       // Bus power flag
   input  wire                  haltHandshakeReceived, // Halt rx flag
   input  wire                  checksumFault,         // Checksum flag
   input  wire                  stuffingFaultFlag,     // Stuffing flag
   input  wire                  rxOverflow,            // Overflow flag
   input  wire                  rxTimeout,             // Timeout flag
   input  wire                  toggleSequenceFlag,    // Toggle flag

   // Processor
   output wire                  irq                    // Interrupt, high
);

   // Bus front end
   wire                   wrEn;
   wire [`UIF_ADDR_W-1:0] wrAddr;
   wire [31:0]            wrData;
   wire [31:0]            wrMask;
   wire [`UIF_ADDR_W-1:0] rdAddr;
   reg                    wrOk;
   reg                    rdOk;
   reg  [31:0]            rdData;

   // Registers
   reg  [`UIF_SRC_N-1:0]  enable_q;
   reg  [`UIF_SRC_N-1:0]  enable_d;
   reg  [`UIF_SRC_N-1:0]  force_q;
   reg  [`UIF_SRC_N-1:0]  force_d;
   reg                    irq_q;
   reg                    primed_q;
   reg                    sleepPrev_q;
   reg                    attachPrev_q;
   reg  [1:0]             speedPrev_q;
   reg                    xferPrev_q;

   // Sources
   wire [`UIF_SRC_N-1:0]  raw;
   wire [`UIF_SRC_N-1:0]  masked;
   // Sticky event bank
   wire [`UIF_EV_N-1:0]   evSet;
   wire [`UIF_EV_N-1:0]   evClr;
   wire [`UIF_EV_N-1:0]   evFlags;
   wire [`UIF_EV_N-1:0]   evW1c;
   wire [`UIF_SRC_N-1:0]  w1cBits;
   wire                   rawWrite;
   wire                   sleepChg;
   wire                   attachChg;
   wire                   speedChg;
   wire                   xferRise;
   wire                   devRole;

   uif_axil_slave #(
      .AW (`UIF_ADDR_W)
   ) uSlave (
      .clk     (clk),
      .srst    (srst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrEn    (wrEn),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrMask  (wrMask),
      .wrOk    (wrOk),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdOk    (rdOk)
   );

   // Role gates new events except the transfer rise; set flags survive a switch
   assign devRole = ~hostRole;

   // Sleep, attach and speed change detectors hold off one cycle after reset so the
   // first sample of a level does not look like a change
   assign sleepChg  = primed_q & (sleepStateFlag ^ sleepPrev_q);
   assign attachChg = primed_q & (attachState ^ attachPrev_q);
   assign speedChg  = primed_q & (speedField != speedPrev_q);
   assign xferRise  = transferFinished & ~xferPrev_q;

   // Level history for the change detectors
   always @(posedge clk) begin
      if (srst) begin
         primed_q     <= 1'b0;
         sleepPrev_q  <= 1'b0;
         attachPrev_q <= 1'b0;
         speedPrev_q  <= 2'h0;
         xferPrev_q   <= 1'b0;
      end else begin
         primed_q     <= 1'b1;
         sleepPrev_q  <= sleepStateFlag;
         attachPrev_q <= attachState;
         speedPrev_q  <= speedField;
         xferPrev_q   <= transferFinished;
      end
   end

   // Sticky events, in order: bits 0, 1, 2, 3, 13, 14, 15, 17
   assign evSet[0] = hostRole & speedChg;
   assign evSet[1] = hostRole & hostWake;
   assign evSet[2] = hostRole & hostFrameSent;
   assign evSet[3] = xferRise;
   assign evSet[4] = devRole & attachChg;
   assign evSet[5] = devRole & sleepChg;
   assign evSet[6] = devRole & deviceWakeFromHost;
   assign evSet[7] = devRole & deviceFrameStart;

   // Raw writes clear event bits only
   assign rawWrite = wrEn & (wrAddr == `UIF_OFF_RAW);
   assign w1cBits  = rawWrite ? (wrData[`UIF_SRC_N-1:0]
                                 & wrMask[`UIF_SRC_N-1:0])
                              : {`UIF_SRC_N{1'b0}};
   // W1C bits in sticky order
   assign evW1c = {w1cBits[`UIF_B_DEVSOF],  w1cBits[`UIF_B_DEVWAKE],
                   w1cBits[`UIF_B_SLEEP],   w1cBits[`UIF_B_DEVATT],
                   w1cBits[`UIF_B_XFER],    w1cBits[`UIF_B_HOSTSOF],
                   w1cBits[`UIF_B_HOSTWAKE], w1cBits[`UIF_B_HOSTATT]};

   // Resume write and frame read clear both roles
   assign evClr[0] = evW1c[0] | speedFieldWrite;
   assign evClr[1] = evW1c[1] | resumeFlagWrite;
   assign evClr[2] = evW1c[2] | frameNumRead;
   assign evClr[3] = evW1c[3];
   assign evClr[4] = evW1c[4] | attachFlagWrite;
   assign evClr[5] = evW1c[5] | sleepFlagWrite;
   assign evClr[6] = evW1c[6] | resumeFlagWrite;
   assign evClr[7] = evW1c[7] | frameNumRead;

   // Set wins over clear in one cycle
   uif_sticky #(
      .N (`UIF_EV_N)
   ) uEvents (
      .clk   (clk),
      .srst  (srst),
      .set   (evSet),
      .clr   (evClr),
      .flags (evFlags)
   );

   // Array summaries follow their arrays; they fall only when all clear
   assign raw[`UIF_B_EPHALT]   = |endpointHaltNackFlags;
   assign raw[`UIF_B_ABORT]    = |abortDoneFlags;
   assign raw[`UIF_B_DEVSOF]   = evFlags[7];
   assign raw[`UIF_B_SETUP]    = setupPacketReceived;
   assign raw[`UIF_B_DEVWAKE]  = evFlags[6];
   assign raw[`UIF_B_SLEEP]    = evFlags[5];
   assign raw[`UIF_B_DEVATT]   = evFlags[4];
   assign raw[`UIF_B_BUSRST]   = busReset;
   assign raw[`UIF_B_VBUS]     = busPowerPresent;
   assign raw[`UIF_B_HALT]     = haltHandshakeReceived;
   assign raw[`UIF_B_CRC]      = checksumFault;
   assign raw[`UIF_B_STUFF]    = stuffingFaultFlag;
   assign raw[`UIF_B_RXOVF]    = rxOverflow;
   assign raw[`UIF_B_RXTMO]    = rxTimeout;
   assign raw[`UIF_B_TOGGLE]   = toggleSequenceFlag;
   assign raw[`UIF_B_BUFDONE]  = |bufferDoneFlags;
   assign raw[`UIF_B_XFER]     = evFlags[3];
   assign raw[`UIF_B_HOSTSOF]  = evFlags[2];
   assign raw[`UIF_B_HOSTWAKE] = evFlags[1];
   assign raw[`UIF_B_HOSTATT]  = evFlags[0];

   // Force raises a bit even when disabled
   assign masked = (raw & enable_q) | force_q;

   // Byte strobes select which enable and force bits a write touches
   always @* begin
      enable_d = enable_q;
      force_d  = force_q;
      if (wrEn && (wrAddr == `UIF_OFF_ENABLE)) begin
         enable_d = (enable_q & ~wrMask[`UIF_SRC_N-1:0])
                    | (wrData[`UIF_SRC_N-1:0] & wrMask[`UIF_SRC_N-1:0]);
      end
      if (wrEn && (wrAddr == `UIF_OFF_FORCE)) begin
         force_d = (force_q & ~wrMask[`UIF_SRC_N-1:0])
                   | (wrData[`UIF_SRC_N-1:0] & wrMask[`UIF_SRC_N-1:0]);
      end
   end

   // Registered irq cannot glitch; trails status a cycle
   always @(posedge clk) begin
      if (srst) begin
         enable_q <= `UIF_ENABLE_RST;
         force_q  <= `UIF_FORCE_RST;
         irq_q    <= 1'b0;
      end else begin
         enable_q <= enable_d;
         force_q  <= force_d;
         irq_q    <= |masked;
      end
   end

   assign irq = irq_q;

   // The status view takes no writes; they are answered but ignored
   always @* begin
      wrOk = 1'b0;
      case (wrAddr)
         `UIF_OFF_RAW:    wrOk = 1'b1;
         `UIF_OFF_ENABLE: wrOk = 1'b1;
         `UIF_OFF_FORCE:  wrOk = 1'b1;
         `UIF_OFF_MASKED: wrOk = 1'b1;
         default:         wrOk = 1'b0;
      endcase
   end

   // Bits 31:20 read zero
   always @* begin
      rdOk   = 1'b1;
      rdData = 32'h00000000;
      case (rdAddr)
         `UIF_OFF_RAW: begin
            rdData = {12'h000, raw};
         end
         `UIF_OFF_ENABLE: begin
            rdData = {12'h000, enable_q};
         end
         `UIF_OFF_FORCE: begin
            rdData = {12'h000, force_q};
         end
         `UIF_OFF_MASKED: begin
            rdData = {12'h000, masked};
         end
         default: begin
            rdOk   = 1'b0;
            rdData = 32'h00000000;
         end
      endcase
   end

endmodule
`default_nettype wire

// file: dv/uif_irq_top_sva.sv
/*
 Checker for the interrupt force and status block: register bus timing,
 reserved bits, error reads and interrupt reset state.
 Assumes binding to uif_irq_top, one clock, synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module uif_irq_top_sva #(
   parameter EP_N  = 32,  // Endpoint flag count
   parameter BUF_N = 32   // Buffer flag count
) (
   input wire logic        clk,      // Bus clock
   input wire logic        srst,     // Sync reset
   input wire logic        awvalid,  // Write address valid
   input wire logic        awready,  // Write address ready
   input wire logic        wvalid,   // Write data valid
   input wire logic        wready,   // Write data ready
   input wire logic [1:0]  bresp,    // Write response
   input wire logic        bvalid,   // Write response valid
   input wire logic        bready,   // Write response ready
   input wire logic        arvalid,  // Read address valid
   input wire logic        arready,  // Read address ready
   input wire logic [31:0] rdata,    // Read data
   input wire logic [1:0]  rresp,    // Read response
   input wire logic        rvalid,   // Read data valid
   input wire logic        rready,   // Read data ready
   input wire logic        irq       // Interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   property p_rsvd; rvalid |-> rdata[31:20] == 12'h000; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_irqRst; $fell(srst) |-> !irq; endproperty
   a_irqRst: assert property (p_irqRst) else $error("irq after reset");
   property p_slvZero; rvalid && rresp == 2'h2 |-> rdata == 32'h00000000; endproperty
   a_slvZero: assert property (p_slvZero) else $error("error read data");
   property p_arRdy; arready == !rvalid; endproperty
   a_arRdy: assert property (p_arRdy) else $error("arready wrong");
   property p_rLat; arvalid && arready |=> rvalid; endproperty
   a_rLat: assert property (p_rLat) else $error("read late");
   property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   a_rHold: assert property (p_rHold) else $error("read dropped");
   property p_bLat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_bLat: assert property (p_bLat) else $error("write late");
   property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bHold: assert property (p_bHold) else $error("write resp dropped");
   property p_bBlock; bvalid |-> !awready && !wready; endproperty
   a_bBlock: assert property (p_bBlock) else $error("accepted while busy");

   c_read: cover property (rvalid && rready);
   c_write: cover property (bvalid && bready);
   c_slverr: cover property (rvalid && rresp == 2'h2);
   c_irq: cover property ($rose(irq));
endmodule

bind uif_irq_top uif_irq_top_sva #(.EP_N(EP_N), .BUF_N(BUF_N)) u_sva (
   .clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .irq(irq));

`default_nettype wire

// file: dv/uif_irq_sink.sv
/*
 Processor-side interrupt sink: counts interrupt requests it sees.
 Assumes a level interrupt on the bus clock.
*/
`timescale 1ns/1ns
`default_nettype none

module uif_irq_sink (
   input  wire logic       clk,      // Bus clock
   input  wire logic       srst,     // Sync reset
   input  wire logic       irq,      // Level interrupt
   output var  logic [7:0] irqRises  // Requests seen
);
   logic irqSeen_q;

   // Counts edges only: a held level is one request, not many
   always @(posedge clk) begin
      if (srst) begin
         irqSeen_q <= 1'b0;
         irqRises  <= 8'h00;
      end else begin
         irqSeen_q <= irq;
         if (irq && !irqSeen_q)
            irqRises <= irqRises + 8'h01;
      end
   end
endmodule

`default_nettype wire

// file: dv/uif_irq_top_tb.sv
/*
 Self-checking bench: AXI4-Lite master, engine stimulus, status model.
 Assumes the design and checker files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module uif_irq_top_tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        hostRole = 1'b0;
   logic [31:0] arr [3] = '{default: 32'h00000000};
   logic [8:0]  lvl = 9'h000;
   logic [12:0] trg = 13'h0000;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [7:0]   irqRises;
   logic [31:0] d;
   logic [1:0]  r;
   int          num_errors = 0, cmp_count = 0, cyc = 0, seed = 89;
   int          en = 0, frc = 0, stk = 0, k, p, q;

   always #25 clk = ~clk;

   uif_irq_top #(.EP_N(32), .BUF_N(32)) u_dut (
      .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .hostRole(hostRole), .endpointHaltNackFlags(arr[0]), .abortDoneFlags(arr[1]),
      .bufferDoneFlags(arr[2]), .deviceFrameStart(trg[0]), .hostFrameSent(trg[1]),
      .frameNumRead(trg[2]), .deviceWakeFromHost(trg[3]), .hostWake(trg[4]),
      .resumeFlagWrite(trg[5]), .sleepFlagWrite(trg[6]), .attachFlagWrite(trg[7]),
      .speedFieldWrite(trg[8]), .sleepStateFlag(trg[9]), .attachState(trg[10]),
      .transferFinished(trg[11]), .speedField({1'b0, trg[12]}),
      .setupPacketReceived(lvl[8]), .busReset(lvl[7]), .busPowerPresent(lvl[6]),
      .haltHandshakeReceived(lvl[5]), .checksumFault(lvl[4]), .stuffingFaultFlag(lvl[3]),
      .rxOverflow(lvl[2]), .rxTimeout(lvl[1]), .toggleSequenceFlag(lvl[0]), .irq(irq));

   uif_irq_sink u_sink (.clk(clk), .srst(srst), .irq(irq), .irqRises(irqRises));

   task automatic summarize();
      $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Raw view rebuilt from the bench's own copy of every source
   function automatic logic [31:0] rawExp();
      logic [31:0] x;
      x = stk;
      x[12:5] = lvl[7:0];
      x[16] = lvl[8];
      x[19] = |arr[0];
      x[18] = |arr[1];
      x[4] = |arr[2];
      return x;
   endfunction

   // Expectation taken after the read so pending input updates have landed
   task automatic chkSt();
      logic [31:0] e;
      rd(8'h98);
      e = (rawExp() & en) | frc;
      chk(d, e);
      chk({30'h0, r}, 32'h0);
      chk({31'h0, irq}, {31'h0, e != 0});
   endtask

   task automatic trig(input int i);
      @(posedge clk);
      trg[i] <= ~trg[i];
      if (i < 9) begin
         @(posedge clk);
         trg[i] <= 1'b0;
      end
   endtask

   task automatic ev(input int s, input int c, input int b);
      trig(s);
      stk |= 1 << b;
      chkSt();
      if (c >= 0) trig(c);
      else wr(8'h8C, 32'h1 << b);
      stk &= ~(1 << b);
      chkSt();
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (k = 0; k < 3; k++) begin
         rd(8'h8C + 8'(4 * k));
         chk(d, 32'h0);
      end
      rd(8'hF0);
      chk({30'h0, r}, 32'h2);
      frc = $random(seed) & 32'h000FFFFF;
      wr(8'h94, frc | 32'hFFF00000);
      rd(8'h94);
      chk(d, frc);
      chkSt();
      wr(8'h98, 32'hFFFFFFFF);
      chk({30'h0, r}, 32'h0);
      chkSt();
      wr(8'hF0, 32'hFFFFFFFF);
      chk({30'h0, r}, 32'h2);
      frc = 0;
      wr(8'h94, 32'h0);
      en = 32'h000FFFFF;
      wr(8'h90, 32'hFFFFFFFF);
      rd(8'h90);
      chk(d, en);
      for (k = 0; k < 9; k++) begin
         @(posedge clk);
         lvl[k] <= 1'b1;
         chkSt();
         lvl[k] <= 1'b0;
      end
      // Two flags per array: the summary must outlive the first clear
      for (k = 0; k < 3; k++) begin
         p = {$random(seed)} % 32;
         q = (p + 1 + {$random(seed)} % 31) % 32;
         @(posedge clk);
         arr[k][p] <= 1'b1;
         arr[k][q] <= 1'b1;
         chkSt();
         arr[k][p] <= 1'b0;
         chkSt();
         arr[k][q] <= 1'b0;
         chkSt();
      end
      ev(0, 2, 17);
      ev(3, 5, 15);
      ev(9, 6, 14);
      ev(10, 7, 13);
      ev(11, -1, 3);
      trig(11);
      trig(1);
      trig(4);
      chkSt();
      ev(11, -1, 3);
      @(posedge clk);
      hostRole <= 1'b1;
      ev(1, 2, 2);
      ev(4, 5, 1);
      ev(12, 8, 0);
      trig(0);
      chkSt();
      en = 0;
      wr(8'h90, 32'h0);
      @(posedge clk);
      lvl[0] <= 1'b1;
      chkSt();
      en = 32'h20;
      wr(8'h90, 32'h20);
      chkSt();
      wstrb <= 4'h2;
      wr(8'h90, 32'hFFFFFFFF);
      wstrb <= 4'hF;
      rd(8'h90);
      chk(d, 32'h0000FF20);
      chk({31'h0, irqRises != 8'h00}, 32'h1);
      summarize();
   end
endmodule

`default_nettype wire
